// ---- flash_pkg.sv ----
// constants, command codes and status layout for the serial flash block
// Contract
// - sample inputs on rise, drive outputs on fall
// - reads auto-increment address, wrap to zero
// - fast read adds one dummy byte
// - faster reads rejected while erase busy
// - dual output: serial address, 8 dummies
// - dual io: 2-bit address, 4 dummies
// - quad reads need quad enable set
// - quad output: serial address, 8 dummies
// - inverting mode byte keeps opcode-free mode
// - non-inverting mode byte or ff exits
// - erase sets sector to ones, needs latch
// - erase dropped unless select rises at boundary
// - sector chosen by address bit 12 upward
// - busy while erasing, then latch clears
// - protected sectors are never erased
// - status bits: busy 0, latch 1, quad 6
package flash_pkg;
   localparam int        CLK_MHZ      = 10;
   // erase time in microseconds; default is arbitrary, top may shorten it
   localparam int        SE_TIME_US   = 1000;
   localparam int        SE_CYC       = SE_TIME_US * CLK_MHZ;
   localparam int        SECTOR_BYTES = 4096;
   localparam int        SECTOR_LSB   = 12;
   localparam int        ADDR_BITS    = 24;
   localparam int        DUMMY_FAST   = 8;
   localparam int        DUMMY_DUAL   = 8;
   localparam int        DUMMY_DIO    = 4;
   localparam int        DUMMY_QUAD   = 8;
   localparam int        DUMMY_QIO    = 4;
   localparam int        MODE_CLKS    = 2;
   // apb register byte offsets
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_MEM_PTR  = 8'h04;
   localparam logic [7:0] OFS_MEM_DATA = 8'h08;
   // status byte fields
   localparam int        ST_BUSY_BIT  = 0;
   localparam int        ST_WEL_BIT   = 1;
   localparam int        ST_BP_LSB    = 2;
   localparam int        ST_QE_BIT    = 6;
   localparam logic [3:0] BP_RESET    = 4'h0;
   localparam logic       QE_RESET    = 1'b0;
   // opcodes: values are arbitrary, not taken from any part
   localparam logic [7:0] OP_READ     = 8'h11;
   localparam logic [7:0] OP_FAST     = 8'h12;
   localparam logic [7:0] OP_DUAL_OUTPUT_READ_CMD    = 8'h13;
   localparam logic [7:0] OP_DIO      = 8'h14;
   localparam logic [7:0] OP_QUAD_OUTPUT_READ_CMD    = 8'h15;
   localparam logic [7:0] OP_QIO      = 8'h16;
   localparam logic [7:0] OP_ERASE    = 8'h21;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h22;
   localparam logic [7:0] OP_EXIT     = 8'hff;
   typedef enum logic [3:0] {
      C_READ, C_FAST, C_DUAL_OUTPUT_READ_CMD, C_DIO, C_QUAD_OUTPUT_READ_CMD, C_QIO,
      C_ERASE, C_WRITE_ENABLE_CMD, C_EXIT, C_NONE
   } cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_TAIL,
      ST_IGNORE
   } frame_t;
endpackage

// ---- host_model.sv ----
// host controller model: select, serial clock and data line driving
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       pclk,           // bench clock, paces the link
   output logic            cs_n = 1'b1,    // chip select, active low
   output logic            sclk = 1'b0,    // serial clock, idles low
   output logic      [3:0] drv = 4'h0,     // host drive values
   output logic      [3:0] drv_oe = 4'h0,  // host drive enables
   input  wire logic [3:0] dl              // resolved data lines
);
   // 800 ns clock; sampling 2 pclk into the high phase clears the
   // device's 3-4 pclk output lag
   task automatic tick(input logic [3:0] v, en, output logic [3:0] s);
      drv <= v;
      drv_oe <= en;
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (2) @(posedge pclk);
      s = dl;
      repeat (2) @(posedge pclk);
      sclk <= 1'b0;
   endtask
   task automatic start();
      @(posedge pclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic stop();
      repeat (4) @(posedge pclk);
      drv_oe <= 4'h0;
      cs_n <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   task automatic send(input logic [31:0] v, input int nb, ln);
      logic [3:0] s;
      for (int i = nb - ln; i >= 0; i -= ln)
         tick(4'((v >> i) & ((1 << ln) - 1)), 4'((1 << ln) - 1), s);
   endtask
   task automatic dummy(input int n);
      logic [3:0] s;
      repeat (n) tick(4'h0, 4'h0, s);
   endtask
   task automatic recv(input int ln, output logic [7:0] b);
      logic [3:0] s;
      b = 8'h00;
      for (int i = 0; i < 8 / ln; i++) begin
         tick(4'h0, 4'h0, s);
         s = (ln == 1) ? {3'b0, s[1]} : s & 4'((1 << ln) - 1);
         b = (b << ln) | {4'h0, s};
      end
   endtask
endmodule
`default_nettype wire

// ---- link_sync.sv ----
// two-flop synchroniser with edge detection for the link pins
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
   parameter int W = 6
) (
   input  wire logic         pclk,     // system clock
   input  wire logic         presetn,  // async reset, active low
   input  wire logic [W-1:0] raw,      // asynchronous pins
   output logic      [W-1:0] q,        // synchronised level
   output logic      [W-1:0] rise,     // one-cycle rising edge
   output logic      [W-1:0] fall      // one-cycle falling edge
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '1;
         sync_r <= '1;
         prev_r <= '1;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign q    = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule
`default_nettype wire

// ---- serial_flash_read_and_sector_erase.sv ----
// serial flash read family and sector erase with apb status access
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_and_sector_erase
   import flash_pkg::*;
#(
   parameter int MEM_AW       = 14,
   parameter int ERASE_CYCLES = SE_CYC
) (
   input  wire logic        pclk,         // system clock, 10 mhz
   input  wire logic        presetn,      // async reset, active low
   input  wire logic [7:0]  paddr,        // apb byte address
   input  wire logic        psel,         // apb select
   input  wire logic        penable,      // apb access phase
   input  wire logic        pwrite,       // apb direction
   input  wire logic [31:0] pwdata,       // apb write data
   output logic      [31:0] prdata,       // apb read data
   output logic             pready,       // apb ready
   output logic             pslverr,      // apb error, unmapped address
   input  wire logic        cs_n,         // chip select, active low
   input  wire logic        sclk,         // serial clock from host
   input  wire logic [3:0]  data_line_in, // data lines 3..0 sensed
   output logic      [3:0]  data_line_out,// data lines 3..0 driven
   output logic      [3:0]  data_line_oe  // per-line drive enable
);
   localparam int NSECT = 1 << (MEM_AW - SECTOR_LSB);
   localparam int ECW   = $clog2(ERASE_CYCLES + 1);

   logic [5:0]        lk_q;
   logic [5:0]        lk_rise;
   logic [5:0]        lk_fall;
   logic              cs_rise_e;
   logic              cs_fall_e;
   logic              sck_rise;
   logic              sck_fall;
   logic [3:0]        din;
   frame_t            state_r;
   cmd_t              cmd_r;
   cmd_t              dec;
   logic [2:0]        lanes_r;
   logic [2:0]        dlanes_r;
   logic [4:0]        cnt_r;
   logic [4:0]        cnt_nxt;
   logic [3:0]        dummy_r;
   logic [23:0]       sh_r;
   logic [23:0]       sh_nxt;
   logic [7:0]        mode_r;
   logic              mode_seen_r;
   logic              cont_r;
   logic              addr_done;
   logic              data_start;
   logic [MEM_AW-1:0] addr_r;
   logic [7:0]        out_sh_r;
   logic [2:0]        grp_r;
   logic              fetch_r;
   logic              wel_r;
   logic              busy_r;
   logic              qe_r;
   logic [3:0]        bp_r;
   logic [ECW-1:0]    erase_cnt_r;
   logic [MEM_AW-SECTOR_LSB-1:0] sector_r;
   logic              prot_hit;
   logic              erase_go;
   logic              write_enable_cmd_go;
   logic              apb_acc;
   logic              pready_r;
   logic [31:0]       prdata_r;
   logic              pslverr_r;
   logic [MEM_AW-1:0] mem_ptr_r;
   logic [7:0]        status;
   logic [7:0]        mem [0:(1<<MEM_AW)-1];

   link_sync #(.W(6)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     ({cs_n, sclk, data_line_in}),
      .q       (lk_q),
      .rise    (lk_rise),
      .fall    (lk_fall)
   );

   assign cs_rise_e = lk_rise[5];
   assign cs_fall_e = lk_fall[5];
   assign sck_rise  = lk_rise[4] & ~lk_q[5];
   assign sck_fall  = lk_fall[4] & ~lk_q[5];
   assign din       = lk_q[3:0];

   // opcode is the seven bits already shifted plus the bit on line 0 now
   always_comb begin
      case ({sh_r[6:0], din[0]})
         OP_READ:  dec = C_READ;
         OP_FAST:  dec = C_FAST;
         OP_DUAL_OUTPUT_READ_CMD: dec = C_DUAL_OUTPUT_READ_CMD;
         OP_DIO:   dec = C_DIO;
         OP_QUAD_OUTPUT_READ_CMD: dec = C_QUAD_OUTPUT_READ_CMD;
         OP_QIO:   dec = C_QIO;
         OP_ERASE: dec = C_ERASE;
         OP_WRITE_ENABLE_CMD:  dec = C_WRITE_ENABLE_CMD;
         OP_EXIT:  dec = C_EXIT;
         default:  dec = C_NONE;
      endcase
   end

   // msb-first: higher-numbered lines carry the higher address bits
   always_comb begin
      case (lanes_r)
         3'd2:    sh_nxt = {sh_r[21:0], din[1:0]};
         3'd4:    sh_nxt = {sh_r[19:0], din};
         default: sh_nxt = {sh_r[22:0], din[0]};
      endcase
      cnt_nxt = cnt_r + 5'(lanes_r);
   end

   // inputs are taken only on rising serial clock edges
   assign addr_done  = sck_rise && state_r == ST_ADDR &&
                       cnt_nxt == 5'(ADDR_BITS);
   assign data_start = (addr_done && cmd_r == C_READ) ||
                       (sck_rise && state_r == ST_DUMMY &&
                        cnt_r == 5'(dummy_r - 4'd1));

   // frame sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= ST_IDLE;
         cmd_r       <= C_NONE;
         lanes_r     <= 3'd1;
         dlanes_r    <= 3'd1;
         cnt_r       <= 5'h0;
         dummy_r     <= 4'h0;
         sh_r        <= 24'h0;
         mode_r      <= 8'h0;
         mode_seen_r <= 1'b0;
      end else if (cs_rise_e) begin
         state_r <= ST_IDLE;
      end else if (cs_fall_e) begin
         cnt_r       <= 5'h0;
         mode_seen_r <= 1'b0;
         if (cont_r && qe_r) begin
            // opcode skipped, frame opens on the address
            state_r  <= ST_ADDR;
            cmd_r    <= C_QIO;
            lanes_r  <= 3'd4;
            dlanes_r <= 3'd4;
         end else begin
            state_r <= ST_CMD;
            lanes_r <= 3'd1;
         end
      end else if (sck_rise) begin
         case (state_r)
            ST_CMD: begin
               sh_r  <= sh_nxt;
               cnt_r <= cnt_r + 5'h1;
               if (cnt_r == 5'd7) begin
                  cmd_r   <= dec;
                  cnt_r   <= 5'h0;
                  state_r <= ST_ADDR;
                  case (dec)
                     C_READ: dlanes_r <= 3'd1;
                     C_FAST: begin
                        dlanes_r <= 3'd1;
                        dummy_r  <= 4'(DUMMY_FAST);
                     end
                     C_DUAL_OUTPUT_READ_CMD: begin
                        dlanes_r <= 3'd2;
                        dummy_r  <= 4'(DUMMY_DUAL);
                     end
                     C_DIO: begin
                        lanes_r  <= 3'd2;
                        dlanes_r <= 3'd2;
                        dummy_r  <= 4'(DUMMY_DIO);
                     end
                     C_QUAD_OUTPUT_READ_CMD: begin
                        dlanes_r <= 3'd4;
                        dummy_r  <= 4'(DUMMY_QUAD);
                     end
                     C_QIO: begin
                        lanes_r  <= 3'd4;
                        dlanes_r <= 3'd4;
                        dummy_r  <= 4'(DUMMY_QIO);
                     end
                     C_ERASE: dlanes_r <= 3'd1;
                     default: state_r <= ST_TAIL;
                  endcase
                  // the running erase carries on untouched
                  if (busy_r && dec inside {C_FAST, C_DUAL_OUTPUT_READ_CMD, C_DIO,
                                            C_QUAD_OUTPUT_READ_CMD, C_QIO})
                     state_r <= ST_IGNORE;
                  if (!qe_r && dec inside {C_QUAD_OUTPUT_READ_CMD, C_QIO})
                     state_r <= ST_IGNORE;
                  if (dec == C_NONE)
                     state_r <= ST_IGNORE;
               end
            end
            ST_ADDR: begin
               sh_r  <= sh_nxt;
               cnt_r <= cnt_nxt;
               if (addr_done) begin
                  cnt_r <= 5'h0;
                  case (cmd_r)
                     C_ERASE: state_r <= ST_TAIL;
                     C_READ:  state_r <= ST_DATA;
                     C_QIO:   state_r <= ST_MODE;
                     default: state_r <= ST_DUMMY;
                  endcase
               end
            end
            ST_MODE: begin
               mode_r <= {mode_r[3:0], din};
               cnt_r  <= cnt_r + 5'h1;
               if (cnt_r == 5'(MODE_CLKS - 1)) begin
                  cnt_r       <= 5'h0;
                  mode_seen_r <= 1'b1;
                  state_r     <= ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               cnt_r <= cnt_r + 5'h1;
               if (data_start)
                  state_r <= ST_DATA;
            end
            // any clock past the boundary spoils the frame
            ST_TAIL:  state_r <= ST_IGNORE;
            default:  state_r <= state_r;
         endcase
      end
   end

   // continuous quad-io mode flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cont_r <= 1'b0;
      end else if (cs_rise_e) begin
         if (state_r == ST_TAIL && cmd_r == C_EXIT)
            cont_r <= 1'b0;
         else if (mode_seen_r)
            cont_r <= mode_r[7:4] == ~mode_r[3:0];
      end
   end

   // read data path: fetch ahead, drive on falling edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r        <= '0;
         out_sh_r      <= 8'h0;
         grp_r         <= 3'h0;
         fetch_r       <= 1'b0;
         data_line_out <= 4'h0;
         data_line_oe  <= 4'h0;
      end else begin
         if (addr_done)
            addr_r <= sh_nxt[MEM_AW-1:0];
         if (data_start) begin
            fetch_r <= 1'b1;
            grp_r   <= 3'h0;
         end else if (fetch_r) begin
            // natural overflow of the counter wraps to zero
            out_sh_r <= mem[addr_r];
            addr_r   <= addr_r + 1'b1;
            fetch_r  <= 1'b0;
         end else if (sck_fall && state_r == ST_DATA) begin
            case (dlanes_r)
               3'd2: begin
                  data_line_out <= {2'b00, out_sh_r[7:6]};
                  data_line_oe  <= 4'h3;
                  out_sh_r      <= {out_sh_r[5:0], 2'b00};
               end
               3'd4: begin
                  data_line_out <= out_sh_r[7:4];
                  data_line_oe  <= 4'hf;
                  out_sh_r      <= {out_sh_r[3:0], 4'h0};
               end
               default: begin
                  data_line_out <= {2'b00, out_sh_r[7], 1'b0};
                  data_line_oe  <= 4'h2;
                  out_sh_r      <= {out_sh_r[6:0], 1'b0};
               end
            endcase
            grp_r <= grp_r + 3'h1;
            if (grp_r == 3'(8 / dlanes_r - 1)) begin
               grp_r   <= 3'h0;
               fetch_r <= 1'b1;
            end
         end
         if (state_r != ST_DATA || lk_q[5])
            data_line_oe <= 4'h0;
      end
   end

   // top sectors protected: 0 none, n protects 2^(n-1) sectors
   always_comb begin
      int nprot;
      nprot = 0;
      if (bp_r != 4'h0)
         nprot = 1 << (int'(bp_r) - 1);
      prot_hit = int'(sh_r[MEM_AW-1:SECTOR_LSB]) >= NSECT - nprot;
   end

   assign erase_go = cs_rise_e && state_r == ST_TAIL && cmd_r == C_ERASE &&
                     wel_r && !busy_r && !prot_hit;
   assign write_enable_cmd_go  = cs_rise_e && state_r == ST_TAIL && cmd_r == C_WRITE_ENABLE_CMD &&
                     !busy_r;

   // status: latch, busy, protection, quad enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wel_r       <= 1'b0;
         busy_r      <= 1'b0;
         qe_r        <= QE_RESET;
         bp_r        <= BP_RESET;
         erase_cnt_r <= '0;
         sector_r    <= '0;
      end else begin
         if (write_enable_cmd_go)
            wel_r <= 1'b1;
         if (erase_go) begin
            busy_r      <= 1'b1;
            erase_cnt_r <= '0;
            sector_r    <= sh_r[MEM_AW-1:SECTOR_LSB];
         end else if (busy_r) begin
            erase_cnt_r <= erase_cnt_r + 1'b1;
            if (erase_cnt_r == ECW'(ERASE_CYCLES - 1)) begin
               busy_r <= 1'b0;
               wel_r  <= 1'b0;
            end
         end
         // stands in for the status write; refused while busy
         if (apb_acc && pwrite && paddr == OFS_STATUS && !busy_r) begin
            qe_r <= pwdata[ST_QE_BIT];
            bp_r <= pwdata[ST_BP_LSB +: 4];
         end
      end
   end

   // array: erase sweeps one byte per clock, apb loads contents
   always_ff @(posedge pclk) begin
      if (busy_r && erase_cnt_r < ECW'(SECTOR_BYTES))
         mem[{sector_r, erase_cnt_r[SECTOR_LSB-1:0]}] <= 8'hff;
      else if (apb_acc && pwrite && paddr == OFS_MEM_DATA && !busy_r)
         mem[mem_ptr_r] <= pwdata[7:0];
   end

   assign status = {1'b0, qe_r, bp_r, wel_r, busy_r};

   // apb slave: one wait state so read data leaves a flop
   assign apb_acc = psel && penable && pready_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0;
         pslverr_r <= 1'b0;
         mem_ptr_r <= '0;
      end else begin
         pready_r <= psel && penable && !pready_r;
         if (psel && penable && !pready_r) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
            case (paddr)
               OFS_STATUS:   prdata_r[7:0] <= status;
               OFS_MEM_PTR:  prdata_r[MEM_AW-1:0] <= mem_ptr_r;
               OFS_MEM_DATA: prdata_r[7:0] <= mem[mem_ptr_r];
               default:      pslverr_r <= 1'b1;
            endcase
         end
         if (apb_acc && pwrite && paddr == OFS_MEM_PTR)
            mem_ptr_r <= pwdata[MEM_AW-1:0];
         else if (apb_acc && paddr == OFS_MEM_DATA && !busy_r)
            mem_ptr_r <= mem_ptr_r + 1'b1;
      end
   end

   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_drive_on_fall: assert property (
      $changed(data_line_out) |-> $past(sck_fall))
      else $error("data lines changed without a serial clock fall");
   a_addr_wraps: assert property (
      fetch_r && !data_start && addr_r == '1 |=> addr_r == '0)
      else $error("read address did not wrap to zero");
   a_busy_rejects: assert property (
      sck_rise && state_r == ST_CMD && cnt_r == 5'd7 && busy_r &&
      dec inside {C_FAST, C_DUAL_OUTPUT_READ_CMD, C_DIO, C_QUAD_OUTPUT_READ_CMD, C_QIO}
      |=> state_r == ST_IGNORE)
      else $error("fast read family accepted while busy");
   a_quad_needs_qe: assert property (
      data_line_oe[3] |-> qe_r && dlanes_r == 3'd4)
      else $error("quad lines driven without quad enable");
   a_dual_lanes: assert property (
      data_line_oe == 4'h3 |-> dlanes_r == 3'd2 && state_r == ST_DATA)
      else $error("two lines driven outside a dual read");
   a_cont_entry: assert property (
      cs_fall_e && !cs_rise_e && cont_r && qe_r
      |=> state_r == ST_ADDR && lanes_r == 3'd4)
      else $error("continuous mode frame did not open on address");
   a_cont_exit: assert property (
      cs_rise_e && mode_seen_r && mode_r[7:4] != ~mode_r[3:0] |=> !cont_r)
      else $error("non-inverting mode byte kept continuous mode");
   a_erase_needs_wel: assert property (
      $rose(busy_r) |-> $past(wel_r) && !$past(prot_hit))
      else $error("erase started without latch or in protected area");
   a_erase_end: assert property (
      $fell(busy_r) |-> !wel_r ##1 !busy_r)
      else $error("latch not cleared when erase finished");
   a_erase_boundary: assert property (
      $rose(busy_r) |-> $past(state_r) == ST_TAIL && $past(cs_rise_e))
      else $error("erase started away from the byte boundary");

   c_quad_read: cover property (sck_fall && state_r == ST_DATA &&
                                dlanes_r == 3'd4);
   c_cont_frame: cover property (cs_fall_e && cont_r);
   c_erase_done: cover property ($fell(busy_r));
   c_wrap: cover property (fetch_r && addr_r == '1);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench: apb register access and host link frames
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import flash_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cs_n;
   logic        sclk;
   logic [3:0]  drv, drv_oe, dout, doe, line;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;
   // an undriven line reads as its pull-up level
   assign line = (doe & dout) | (~doe & drv_oe & drv) | (~doe & ~drv_oe);
   always #50 pclk = ~pclk;
   host_model host (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .drv(drv),
                    .drv_oe(drv_oe), .dl(line));
   // short erase keeps the run brief; still covers a full sector sweep
   serial_flash_read_and_sector_erase #(.ERASE_CYCLES(4096)) DUT (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
      .sclk(sclk), .data_line_in(line), .data_line_out(dout),
      .data_line_oe(doe));
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] g, x);
      n_compared++;
      if (g !== x) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      if (n >= 50)
         mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic stat(input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk(r, {24'h0, x});
   endtask
   task automatic memrd(input logic [31:0] p, input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      wr(OFS_MEM_PTR, p);
      apb(1'b0, OFS_MEM_DATA, 32'h0, r, e);
      chk(r, {24'h0, x});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                      input int nb);
      host.start();
      host.send({24'h0, op}, 8, 1);
      if (nb > 0)
         host.send({8'h0, a}, nb, 1);
      host.stop();
   endtask
   task automatic rd(input logic [7:0] op, input logic [23:0] a,
                     input int al, dm, dn, input logic [7:0] md,
                     input logic [31:0] x);
      logic [7:0] b;
      host.start();
      if (op !== 8'h00)
         host.send({24'h0, op}, 8, 1);
      host.send({8'h0, a}, 24, al);
      if (al == 4)
         host.send({24'h0, md}, 8, 4);
      host.dummy(dm);
      for (int k = 0; k < 4; k++) begin
         host.recv(dn, b);
         chk({24'h0, b}, {24'h0, x[31 - 8 * k -: 8]});
      end
      host.stop();
   endtask
   initial begin
      logic [31:0] r;
      logic        e;
      int          n;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      stat(8'h00);
      apb(1'b0, 8'h0c, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      wr(OFS_MEM_PTR, 32'h3ffe);
      wr(OFS_MEM_DATA, 32'ha1);
      wr(OFS_MEM_DATA, 32'hb2);
      wr(OFS_MEM_PTR, 32'h0);
      wr(OFS_MEM_DATA, 32'hc3);
      wr(OFS_MEM_DATA, 32'hd4);
      rd(OP_READ, 24'h3ffe, 1, 0, 1, 8'h0, 32'ha1b2c3d4);
      rd(OP_FAST, 24'h3ffe, 1, 8, 1, 8'h0, 32'ha1b2c3d4);
      rd(OP_DUAL_OUTPUT_READ_CMD, 24'h3ffe, 1, 8, 2, 8'h0, 32'ha1b2c3d4);
      rd(OP_DIO, 24'h3ffe, 2, 4, 2, 8'h0, 32'ha1b2c3d4);
      rd(OP_QUAD_OUTPUT_READ_CMD, 24'h3ffe, 1, 8, 4, 8'h0, 32'hffffffff);
      wr(OFS_STATUS, 32'h40);
      rd(OP_QUAD_OUTPUT_READ_CMD, 24'h3ffe, 1, 8, 4, 8'h0, 32'ha1b2c3d4);
      rd(OP_QIO, 24'h3ffe, 4, 4, 4, 8'ha5, 32'ha1b2c3d4);
      rd(8'h00, 24'h3ffe, 4, 4, 4, 8'hff, 32'ha1b2c3d4);
      rd(OP_READ, 24'h3ffe, 1, 0, 1, 8'h0, 32'ha1b2c3d4);
      wr(OFS_MEM_PTR, 32'h1fff);
      wr(OFS_MEM_DATA, 32'h11);
      wr(OFS_MEM_DATA, 32'h22);
      wr(OFS_MEM_PTR, 32'h1000);
      wr(OFS_MEM_DATA, 32'h33);
      cmd(OP_ERASE, 24'h1234, 24);
      stat(8'h40);
      cmd(OP_WRITE_ENABLE_CMD, 24'h0, 0);
      cmd(OP_ERASE, 24'h1234, 23);
      stat(8'h42);
      cmd(OP_ERASE, 24'h1234, 24);
      stat(8'h43);
      rd(OP_FAST, 24'h2000, 1, 8, 1, 8'h0, 32'hffffffff);
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, r, e);
         n++;
      end while (r[0] !== 1'b0 && n < 3000);
      stat(8'h40);
      memrd(32'h1000, 8'hff);
      memrd(32'h1fff, 8'hff);
      memrd(32'h2000, 8'h22);
      wr(OFS_STATUS, 32'h44);
      cmd(OP_WRITE_ENABLE_CMD, 24'h0, 0);
      cmd(OP_ERASE, 24'h3ffe, 24);
      stat(8'h46);
      memrd(32'h3ffe, 8'ha1);
      stop_test();
   end
endmodule
`default_nettype wire
